//--- crfg_pkg.sv
// Package of constants and carrier types for the receive FIFO release guard
package crfg_pkg;

   // ==========================================================
   // Register fields
   localparam logic [7:0] CRFG_COUNT_MASK     = 8'h03;
   localparam logic [1:0] CRFG_COUNT_CRITICAL = 2'h2;
   localparam logic [7:0] CRFG_RECEIVING_MASK = 8'h20;
   localparam logic [7:0] CRFG_RXPIN_MASK     = 8'h08;
   localparam int         CRFG_RECEIVING_BIT  = 5;
   localparam int         CRFG_RXPIN_BIT      = 3;
   localparam int         CRFG_RELEASE_BIT    = 5;
   localparam int         CRFG_FIFO_DEPTH     = 3;

   // ==========================================================
   // Timing
   localparam int CRFG_BIT_CYCLES      = 8;
   localparam int CRFG_ACK_GAP_CYCLES  = 52;
   localparam int CRFG_CRIT_BITS       = 6;
   localparam int CRFG_RECEIVING_CLEAR_BITS = 8;
   localparam int CRFG_MAX_RECESSIVE   = 5;
   localparam int CRFG_RECESSIVE_LIMIT = 8;
   localparam int CRFG_RELEASE_LIMIT   = 15;
   localparam int CRFG_CNT_W           = 8;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CRFG_IDLE    = 3'h0,
      CRFG_TEST    = 3'h1,
      CRFG_WAIT    = 3'h3,
      CRFG_RELEASE = 3'h2,
      CRFG_FAULT   = 3'h6
   } crfg_state_t;

   typedef struct packed {
      logic       store_req;
      logic [7:0] store_data;
   } crfg_rx_t;

   typedef struct packed {
      logic [1:0] pending_msg_count;
      logic       receiving_flag;
      logic       rx_sample;
      logic       fault;
   } crfg_status_t;

endpackage : crfg_pkg

//--- crfg_mem.sv
// Small message store with registered read data
`timescale 1ns/10ps
module crfg_mem #(
   parameter int DEPTH = 3,
   parameter int WIDTH = 8
) (
   // Clock
   input  wire logic                     clk,
   // Write port
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : crfg_mem

//--- crfg_guard.sv
// Receive FIFO with release defect, frame tracker and release guard sequencer
//
// What this block does
// - Two pending, release meets store: read pointer stalls, count holds at two.
// - After fault, new messages overwrite newest entry; only reset recovers.
// - Receiving flag on status bit 5, zero when no frame receiving.
// - Critical store point lies six bits plus sample time after acknowledge.
// - Dominant sample during reception: release immediately, store is far off.
// - One bit is 8 cycles; 52 cycles before critical interval.
// - Receive pin never recessive over five bits within a frame.
// - Receiving flag clears eight bit times after acknowledge.
`timescale 1ns/10ps
module crfg_guard
   import crfg_pkg::*;
#(
   parameter int BIT_CYCLES = crfg_pkg::CRFG_BIT_CYCLES,
   parameter int DATA_W     = 8
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Receive pin and frame events
   input  wire logic                   can_rx,
   input  wire logic                   frame_active,
   input  wire crfg_pkg::crfg_rx_t     rx_in,
   // Host release request
   input  wire logic                   release_req,
   input  wire logic                   alt_mode,
   output logic                        release_busy,
   output logic                        release_output_mailbox,
   // Output mailbox and status
   output logic        [DATA_W-1:0]    mailbox_data,
   output logic        [7:0]           rx_fifo_reg,
   output logic        [7:0]           master_status_reg,
   output logic        [7:0]           diagnostic_reg,
   output crfg_pkg::crfg_status_t      status
);
   import crfg_pkg::*;

   localparam int PTR_W = $clog2(CRFG_FIFO_DEPTH);
   localparam int LIMIT = CRFG_RECESSIVE_LIMIT * BIT_CYCLES;

   // ==========================================================
   // Pin synchroniser
   logic rx_meta, rx_sync, act_meta, act_sync;
   always_ff @(posedge clk) begin
      rx_meta  <= can_rx;
      rx_sync  <= rx_meta;
      act_meta <= frame_active;
      act_sync <= act_meta;
   end

   // ==========================================================
   // Receiving flag and tracker
   logic receiving_flag, next_receiving_flag;
   always_comb begin
      next_receiving_flag = act_sync;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         receiving_flag <= 1'b0;
      end else begin
         receiving_flag <= next_receiving_flag;
      end
   end

   // ==========================================================
   // FIFO with pointer defect
   logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [1:0]       pending_msg_count, next_count;
   logic             fault, next_fault;
   logic             pop, push;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(CRFG_FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   always_comb begin
      pop         = release_output_mailbox && (pending_msg_count != 2'h0);
      push        = rx_in.store_req;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = pending_msg_count;
      next_fault  = fault;
      if (pop && push && pending_msg_count == CRFG_COUNT_CRITICAL) begin
         next_fault = 1'b1;
      end
      if (pop && !(push && pending_msg_count == CRFG_COUNT_CRITICAL)) begin
         next_rd_ptr = ptr_inc(rd_ptr);
      end
      if (push && (pending_msg_count != 2'h3 || pop)) begin
         if (!fault) begin
            next_wr_ptr = ptr_inc(wr_ptr);
         end else begin
            next_wr_ptr = wr_ptr;
         end
      end
      if (push && !pop && pending_msg_count != 2'h3) begin
         next_count = pending_msg_count + 2'h1;
      end else if (pop && !push) begin
         next_count = pending_msg_count - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr            <= '0;
         rd_ptr            <= '0;
         pending_msg_count <= 2'h0;
         fault             <= 1'b0;
      end else begin
         wr_ptr            <= next_wr_ptr;
         rd_ptr            <= next_rd_ptr;
         pending_msg_count <= next_count;
         fault             <= next_fault;
      end
   end

   // Store slot: in fault state the newest entry is overwritten
   logic [PTR_W-1:0] store_addr;
   always_comb begin
      store_addr = fault ? ((wr_ptr == '0) ? PTR_W'(CRFG_FIFO_DEPTH - 1) : wr_ptr - 1'b1)
                         : wr_ptr;
   end

   crfg_mem #(
      .DEPTH (CRFG_FIFO_DEPTH),
      .WIDTH (DATA_W)
   ) u_mem (
      .clk     (clk),
      .wr_en   (push && (pending_msg_count != 2'h3 || pop || fault)),
      .wr_addr (store_addr),
      .wr_data (rx_in.store_data),
      .rd_addr (next_rd_ptr),
      .rd_data (mailbox_data)
   );

   // ==========================================================
   // Guard sequencer
   crfg_state_t           state, next_state;
   logic [CRFG_CNT_W-1:0] wait_cnt, next_wait_cnt;

   always_comb begin
      next_state    = state;
      next_wait_cnt = wait_cnt;
      case (state)
         CRFG_IDLE: begin
            if (release_req) begin
               next_state = CRFG_TEST;
            end
         end
         CRFG_TEST: begin
            next_wait_cnt = '0;
            if ((rx_fifo_reg & CRFG_COUNT_MASK) != {6'h00, CRFG_COUNT_CRITICAL}) begin
               next_state = CRFG_RELEASE;
            end else if ((master_status_reg & CRFG_RECEIVING_MASK) == 8'h00) begin
               next_state = CRFG_RELEASE;
            end else begin
               next_state = CRFG_WAIT;
            end
         end
         CRFG_WAIT: begin
            // Poll every cycle so a single dominant bit is never missed
            if ((master_status_reg & CRFG_RECEIVING_MASK) == 8'h00 ||
                (diagnostic_reg & CRFG_RXPIN_MASK) == 8'h00) begin
               next_state = CRFG_RELEASE;
            end else if (alt_mode && wait_cnt >= CRFG_CNT_W'(LIMIT)) begin
               next_state = CRFG_RELEASE;
            end else if (wait_cnt != '1) begin
               next_wait_cnt = wait_cnt + 1'b1;
            end
         end
         CRFG_RELEASE: begin
            next_state = CRFG_IDLE;
         end
         default: begin
            next_state = CRFG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state    <= CRFG_IDLE;
         wait_cnt <= '0;
      end else begin
         state    <= next_state;
         wait_cnt <= next_wait_cnt;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      release_output_mailbox = (state == CRFG_RELEASE);
      release_busy           = (state != CRFG_IDLE);
      rx_fifo_reg            = {6'h00, pending_msg_count};
      master_status_reg      = 8'h00;
      master_status_reg[CRFG_RECEIVING_BIT] = receiving_flag;
      diagnostic_reg         = 8'h00;
      diagnostic_reg[CRFG_RXPIN_BIT]  = rx_sync;
      status.pending_msg_count = pending_msg_count;
      status.receiving_flag    = receiving_flag;
      status.rx_sample         = rx_sync;
      status.fault             = fault;
   end
endmodule : crfg_guard

//--- crfg_guard_asserts.sv
// Port checks for the receive FIFO release guard
`timescale 1ns/10ps
module crfg_guard_asserts
   import crfg_pkg::*;
(
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // Host and store side
   input wire crfg_pkg::crfg_rx_t    rx_in,
   input wire logic                  release_req,
   // Guard outputs
   input wire logic                  release_busy,
   input wire logic                  release_output_mailbox,
   input wire logic [7:0]            rx_fifo_reg,
   input wire logic [7:0]            master_status_reg,
   input wire logic [7:0]            diagnostic_reg,
   input wire crfg_pkg::crfg_status_t status
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [1:0] cnt = status.pending_msg_count;
   wire logic       rel = release_output_mailbox;
   property p_msr; master_status_reg == {2'h0, status.receiving_flag, 5'h0}; endproperty
   a_msr: assert property (p_msr) else $error("status layout");
   property p_fifo; rx_fifo_reg == {6'h0, cnt}; endproperty
   a_fifo: assert property (p_fifo) else $error("count layout");
   property p_imm; release_req && !release_busy && (cnt != 2'h2 || !status.receiving_flag)
      |-> ##2 rel; endproperty
   a_imm: assert property (p_imm) else $error("late release");
   property p_once; rel |=> !rel && !release_busy; endproperty
   a_once: assert property (p_once) else $error("release not single");
   property p_run; release_busy && !rel |=> release_busy; endproperty
   a_run: assert property (p_run) else $error("sequence broken before release");
   property p_dom; release_busy && status.receiving_flag && !diagnostic_reg[3] |-> ##[0:2] rel;
   endproperty
   a_dom: assert property (p_dom) else $error("dominant not released");
   property p_pop; rel && !rx_in.store_req && cnt != 2'h0 |=> cnt == $past(cnt) - 2'h1; endproperty
   a_pop: assert property (p_pop) else $error("count not popped");
   property p_flt; rel && rx_in.store_req && cnt == 2'h2 |=> status.fault && cnt == 2'h2;
   endproperty
   a_flt: assert property (p_flt) else $error("fault not raised");
   property p_keep; status.fault |=> status.fault; endproperty
   a_keep: assert property (p_keep) else $error("fault lost");
   c_wait: cover property (release_req && cnt == 2'h2 && status.receiving_flag);
   c_flt: cover property (rel && rx_in.store_req);
   c_tail: cover property (rx_in.store_req && release_busy);
endmodule : crfg_guard_asserts

bind crfg_guard crfg_guard_asserts i_asserts (.clk, .rst, .rx_in, .release_req, .release_busy,
   .release_output_mailbox, .rx_fifo_reg, .master_status_reg, .diagnostic_reg, .status);

//--- crfg_can_model.sv
// Receive side of the bus feeding the guard
`timescale 1ns/10ps
module crfg_can_model
   import crfg_pkg::*;
#(
   parameter int BIT_CYCLES = 8
) (
   // Clock
   input  wire logic         clk,
   // Bus side
   output logic              can_rx,
   output logic              frame_active,
   output crfg_pkg::crfg_rx_t rx_in
);
   initial begin
      can_rx = 1'b1;
      frame_active = 1'b0;
      rx_in = '0;
   end
   // One message, data inverted once the strobe drops
   task automatic store(input logic [7:0] d);
      @(negedge clk);
      rx_in = '{1'b1, d};
      @(negedge clk);
      rx_in = '{1'b0, ~d};
   endtask : store
   // Frame end: acknowledge, store point, flag drop
   task automatic tail();
      frame_active = 1'b1;
      can_rx = 1'b0;
      repeat (BIT_CYCLES) @(negedge clk);
      can_rx = 1'b1;
      repeat (6 * BIT_CYCLES + 3) @(negedge clk);
      store(8'h5c);
      repeat (2 * BIT_CYCLES - 5) @(negedge clk);
      frame_active = 1'b0;
   endtask : tail
endmodule : crfg_can_model

//--- crfg_guard_tb.sv
// Self-checking bench for the receive FIFO release guard
`timescale 1ns/10ps
module crfg_guard_tb;
   import crfg_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         release_req = 1'b0;
   logic         alt_mode = 1'b0;
   logic         can_rx, frame_active, release_busy, release_output_mailbox;
   crfg_rx_t     rx_in;
   logic [7:0]   mailbox_data, rx_fifo_reg, master_status_reg, diagnostic_reg;
   crfg_status_t status;
   int           miscompares = 0;
   int           n_tests = 0;
   int           n;
   always #50 clk = ~clk;
   crfg_can_model i_can (.clk, .can_rx, .frame_active, .rx_in);
   crfg_guard i_dut (.clk, .rst, .can_rx, .frame_active, .rx_in, .release_req, .alt_mode,
      .release_busy, .release_output_mailbox, .mailbox_data, .rx_fifo_reg,
      .master_status_reg, .diagnostic_reg, .status);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Reset, then store k messages
   task automatic start(input int k);
      rst = 1'b1;
      i_can.frame_active = 1'b0;
      i_can.can_rx = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < k; i++) i_can.store(8'(8'ha1 + i));
      repeat (3) @(negedge clk);
   endtask : start
   // Request a release, count cycles to the pulse
   task automatic rel();
      release_req = 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         release_req = 1'b0;
         n++;
      end while (release_output_mailbox !== 1'b1 && n < 300);
   endtask : rel
   task automatic t_imm();
      start(3);
      i_can.frame_active = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (i == 1) i_can.frame_active = 1'b0;
         repeat (3) @(negedge clk);
         chk(master_status_reg, (i == 0) ? 8'h20 : 8'h00);
         chk(rx_fifo_reg, 8'(3 - i));
         if (i < 3) chk(mailbox_data, 8'(8'ha1 + i));
         rel();
         chk(8'(n), 8'h02);
      end
      $display("prompt release done");
   endtask : t_imm
   task automatic t_dom();
      start(2);
      i_can.frame_active = 1'b1;
      repeat (3) @(negedge clk);
      fork
         begin
            repeat (30) @(negedge clk);
            i_can.can_rx = 1'b0;
            repeat (CRFG_BIT_CYCLES) @(negedge clk);
            i_can.can_rx = 1'b1;
         end
         rel();
      join
      chk(8'(n > 30 && n < 45), 8'h01);
      $display("dominant release done");
   endtask : t_dom
   task automatic t_alt();
      start(2);
      alt_mode = 1'b1;
      i_can.frame_active = 1'b1;
      repeat (3) @(negedge clk);
      rel();
      chk(8'(n >= 64 && n <= 70), 8'h01);
      alt_mode = 1'b0;
      $display("recessive limit done");
   endtask : t_alt
   task automatic t_tail();
      start(2);
      fork
         i_can.tail();
         begin
            repeat (16) @(negedge clk);
            rel();
         end
      join
      chk(8'(n > 44 && n < 81), 8'h01);
      @(negedge clk);
      chk(rx_fifo_reg, 8'h02);
      chk(8'(status.fault), 8'h00);
      chk(mailbox_data, 8'ha2);
      $display("frame end done");
   endtask : t_tail
   task automatic t_fault();
      start(2);
      release_req = 1'b1;
      @(negedge clk);
      release_req = 1'b0;
      i_can.store(8'h77);
      chk(8'(status.fault), 8'h01);
      chk(rx_fifo_reg, 8'h02);
      chk(mailbox_data, 8'ha1);
      i_can.store(8'h88);
      chk(8'(status.fault), 8'h01);
      rel();
      @(negedge clk);
      chk(mailbox_data, 8'ha2);
      rel();
      @(negedge clk);
      chk(mailbox_data, 8'h88);
      start(0);
      chk(8'(status.fault), 8'h00);
      $display("fault done");
   endtask : t_fault
   task automatic final_report();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // Tests need well under a thousand cycles
   initial begin
      #1000000;
      miscompares++;
      final_report();
   end
   initial begin
      t_imm();
      t_dom();
      t_alt();
      t_tail();
      t_fault();
      final_report();
   end
endmodule : crfg_guard_tb
